/* logic/serial_reg_pkg.sv */
/*
  Shared constants of the serial register port: register addresses,
  field positions, reset values and timing counts.
  Assumes a 20 MHz core clock and 7-bit register addresses.
*/
package serial_reg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int AW       = 7;    // Address field bits
  localparam int DW       = 8;    // Data field bits
  localparam int NUM_REGS = 91;   // Implemented byte locations
  localparam int NUM_SRC  = 3;    // Equipment clock inputs
  localparam int IRQ_W    = 5;    // Interrupt status bits

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] A_ID_LO    = 7'h00;
  localparam logic [6:0] A_ID_HI    = 7'h01;
  localparam logic [6:0] A_REV      = 7'h02;
  localparam logic [6:0] A_LIVE     = 7'h03;
  localparam logic [6:0] A_IRQ_STS  = 7'h05;
  localparam logic [6:0] A_IRQ_MASK = 7'h06;
  localparam logic [6:0] A_STRAP    = 7'h07;
  localparam logic [6:0] A_CFG_LO   = 7'h0C;
  localparam logic [6:0] A_CFG_HI   = 7'h0D;
  localparam logic [6:0] A_STS_LO   = 7'h0E;
  localparam logic [6:0] A_STS_HI   = 7'h0F;
  localparam logic [6:0] A_IRQ_CFG  = 7'h5A;
  localparam logic [6:0] A_LIMIT    = 7'h5B;  // First undefined

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int IRQ_OPSTATE = 3;  // Operating state changed
  localparam int IRQ_LOSS    = 4;  // Brief loss of selected input
  localparam int CFG_POL     = 0;  // 1: request active high
  localparam int CFG_DRIVE   = 1;  // 1: driven when inactive
  localparam int FRAME_LAST  = 15; // Last command/data bit index
  localparam int FRAME_END   = 23; // Last read data bit index
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [4:0]  RST_MASK  = 5'h00;
  localparam logic [1:0]  RST_ICFG  = 2'h0;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  NO_DATA   = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;
  localparam int POR_HOLD_MS     = 250;
  localparam int POR_HOLD_CYCLES = POR_HOLD_MS * (CLK_HZ / 1000);

endpackage

/* logic/reg_xfer_if.sv */
/*
  Carrier between the serial link logic and the register core.
  Requests and answers are toggles; words stay stable while the
  far side synchronises the toggle.
*/
`timescale 1ns/1ps
interface reg_xfer_if;
  logic [6:0] addr;      // Link domain
  logic [7:0] wdata;     // Link domain
  logic       wr_tgl;    // Link domain
  logic       rd_tgl;    // Link domain
  logic [7:0] rd_data;   // Core domain
  logic       rd_ack;    // Core domain

  modport link (output addr, wdata, wr_tgl, rd_tgl,
                input  rd_data, rd_ack);
  modport core (input  addr, wdata, wr_tgl, rd_tgl,
                output rd_data, rd_ack);
endinterface

/* logic/por_hold.sv */
/*
  Reset stretcher: power-on pin or rst reset asynchronously, and
  the release is held off for a programmable count of clocks.
  Assumes clock runs while the pin is low.
*/
`timescale 1ns/1ps
module por_hold #(
  parameter int HOLD_CYCLES = serial_reg_pkg::POR_HOLD_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic power_on_reset_n,
  output logic      dev_rst_r
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic          arst;
  logic          rel_s1_r;
  logic          rel_s2_r;
  logic [CW-1:0] cnt_r;

  assign arst = rst | ~power_on_reset_n;

  // ----------------------------------------------------------------
  // Release synchroniser and hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      rel_s1_r <= 1'b1;
      rel_s2_r <= 1'b1;
    end else begin
      rel_s1_r <= 1'b0;
      rel_s2_r <= rel_s1_r;
    end
  end

  // Count starts only once the release is synchronised
  always_ff @(posedge clock or posedge arst) begin
    if (arst) begin
      cnt_r     <= '0;
      dev_rst_r <= 1'b1;
    end else if (!rel_s2_r && dev_rst_r) begin
      if (cnt_r == CW'(HOLD_CYCLES - 1)) begin
        dev_rst_r <= 1'b0;
      end
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // por_hold

/* logic/serial_link.sv */
/*
  Serial link front end on the host's serial clock. Shifts the
  address, read flag and data LSB first and hands words to the core.
  Assumes the serial clock may stop while chip select is high.
*/
`timescale 1ns/1ps
module serial_link (
  input  wire logic serial_clock,
  input  wire logic link_rst,
  input  wire logic chip_select_n,
  input  wire logic serial_data_in,
  input  wire logic output_edge_select,
  output logic      serial_data_out,
  output logic      serial_data_out_oe,
  reg_xfer_if.link  xf
);
  logic [4:0]  cnt_r;
  logic [15:0] rx_r;
  logic [7:0]  tx_r;
  logic        rise_out_r;
  logic        fall_out_r;
  logic        oe_r;
  logic        edge_s1_r;
  logic        edge_s2_r;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        fr_rst;

  // Chip select high clears the frame without needing a clock
  assign fr_rst = chip_select_n | link_rst;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock or posedge fr_rst) begin
    if (fr_rst) begin
      cnt_r      <= '0;
      rx_r       <= '0;
      tx_r       <= '0;
      rise_out_r <= 1'b0;
      oe_r       <= 1'b0;
    end else begin
      rx_r <= {serial_data_in, rx_r[15:1]};
      if (cnt_r != 5'(serial_reg_pkg::FRAME_END + 1)) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (cnt_r == 5'(serial_reg_pkg::FRAME_LAST) && rx_r[8]) begin
        oe_r <= 1'b1;
        // Stale answer reads as all ones rather than old data
        if (ack_s2_r == xf.rd_tgl) begin
          rise_out_r <= xf.rd_data[0];
          tx_r       <= {1'b0, xf.rd_data[7:1]};
        end else begin
          rise_out_r <= 1'b1;
          tx_r       <= serial_reg_pkg::NO_DATA;
        end
      end else if (cnt_r > 5'(serial_reg_pkg::FRAME_LAST) &&
                   cnt_r < 5'(serial_reg_pkg::FRAME_END)) begin
        rise_out_r <= tx_r[0];
        tx_r       <= {1'b0, tx_r[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Request toggles, kept across frames
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      xf.addr   <= '0;
      xf.wdata  <= '0;
      xf.wr_tgl <= 1'b0;
      xf.rd_tgl <= 1'b0;
    end else if (!chip_select_n) begin
      if (cnt_r == 5'd7 && serial_data_in) begin
        xf.addr   <= rx_r[15:9];
        xf.rd_tgl <= ~xf.rd_tgl;
      end else if (cnt_r == 5'(serial_reg_pkg::FRAME_LAST) &&
                   !rx_r[8]) begin
        xf.addr   <= rx_r[7:1];
        xf.wdata  <= {serial_data_in, rx_r[15:9]};
        xf.wr_tgl <= ~xf.wr_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers for the answer toggle and edge select pin
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      edge_s1_r <= 1'b0;
      edge_s2_r <= 1'b0;
    end else begin
      ack_s1_r  <= xf.rd_ack;
      ack_s2_r  <= ack_s1_r;
      edge_s1_r <= output_edge_select;
      edge_s2_r <= edge_s1_r;
    end
  end

  // Falling edge copy delays launch by half a serial clock
  always_ff @(negedge serial_clock or posedge fr_rst) begin
    if (fr_rst) begin
      fall_out_r <= 1'b0;
    end else begin
      fall_out_r <= rise_out_r;
    end
  end

  assign serial_data_out    = edge_s2_r ? fall_out_r : rise_out_r;
  assign serial_data_out_oe = oe_r;
endmodule // serial_link

/* logic/serial_register_port.sv */
/*
  Serial register port top: reset stretcher, serial link, 91-byte
  register space with coherent multi-byte access, write-one-to-clear
  interrupt status and a configurable interrupt request pin.
  Assumes status inputs come from logic on the core clock.
*/
`timescale 1ns/1ps
module serial_register_port #(
  parameter int         POR_HOLD = serial_reg_pkg::POR_HOLD_CYCLES,
  parameter logic [15:0] CHIP_ID = 16'h1234, // Arbitrary value
  parameter logic [7:0]  CHIP_REV = 8'h01    // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        power_on_reset_n,
  input  wire logic        serial_clock,
  input  wire logic        chip_select_n,
  input  wire logic        serial_data_in,
  input  wire logic        output_edge_select,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  input  wire logic [2:0]  equipment_clock_valid,
  input  wire logic [1:0]  operating_state,
  input  wire logic        selected_input_lost,
  input  wire logic [15:0] status_word,
  input  wire logic [7:0]  config_strap,
  output logic             interrupt_request,
  output logic             interrupt_request_oe,
  output logic [15:0]      config_word,
  output logic             test_mode,
  output logic             in_reset
);
  logic       dev_rst_r;
  logic       wr_s1_r, wr_s2_r, wr_s3_r;
  logic       rd_s1_r, rd_s2_r, rd_s3_r;
  logic       wr_evt;
  logic       rd_evt;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] cfg_r [0:serial_reg_pkg::NUM_REGS-1];
  logic [7:0] strap_s1_r, strap_s2_r;
  logic [2:0] load_strap_r;
  logic [4:0] irq_sts_r;
  logic [4:0] irq_set;
  logic [4:0] irq_clr;
  logic [4:0] irq_mask_r;
  logic [1:0] irq_cfg_r;
  logic [2:0] valid_d_r;
  logic [1:0] state_d_r;
  logic [7:0] live_shadow_r;
  logic [15:0] word_shadow_r;
  logic [7:0] frozen_hi_r;
  logic       frozen_r;
  logic [7:0] pend_lo_r;
  logic       seq_lo_r;
  logic [15:0] cfg_word_r;
  logic       test_mode_r;
  logic [7:0] rd_mux;
  logic       irq_act;
  logic       irq_out_r;
  logic       irq_oe_r;

  reg_xfer_if xf ();

  // ----------------------------------------------------------------
  // Reset and link
  // ----------------------------------------------------------------
  por_hold #(
    .HOLD_CYCLES (POR_HOLD)
  ) u_por (
    .clock            (clock),
    .rst              (rst),
    .power_on_reset_n (power_on_reset_n),
    .dev_rst_r        (dev_rst_r)
  );

  serial_link u_link (
    .serial_clock       (serial_clock),
    .link_rst           (dev_rst_r),
    .chip_select_n      (chip_select_n),
    .serial_data_in     (serial_data_in),
    .output_edge_select (output_edge_select),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .xf                 (xf)
  );

  assign in_reset = dev_rst_r;
  assign addr     = xf.addr;
  assign wdata    = xf.wdata;

  // ----------------------------------------------------------------
  // Request toggle synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_s3_r <= 1'b0;
    end else begin
      wr_s1_r <= xf.wr_tgl;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      rd_s1_r <= xf.rd_tgl;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
    end
  end

  // Address and data are settled once the toggle has crossed
  assign wr_evt = wr_s2_r ^ wr_s3_r;
  assign rd_evt = rd_s2_r ^ rd_s3_r;

  // ----------------------------------------------------------------
  // Strap capture for pin-set defaults
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      strap_s1_r   <= serial_reg_pkg::RST_BYTE;
      strap_s2_r   <= serial_reg_pkg::RST_BYTE;
      load_strap_r <= 3'h1;
    end else begin
      strap_s1_r   <= config_strap;
      strap_s2_r   <= strap_s1_r;
      load_strap_r <= {load_strap_r[1:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Plain configuration bytes
  // ----------------------------------------------------------------
  // Strap byte is loaded on the third edge after release, once the
  // pin level has passed both synchroniser stages after their reset.
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      for (int i = 0; i < serial_reg_pkg::NUM_REGS; i++) begin
        cfg_r[i] <= serial_reg_pkg::RST_BYTE;
      end
    end else if (load_strap_r[2]) begin
      cfg_r[serial_reg_pkg::A_STRAP] <= strap_s2_r;
    end else if (wr_evt && addr < serial_reg_pkg::A_LIMIT) begin
      cfg_r[addr] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      valid_d_r <= '0;
      state_d_r <= '0;
    end else begin
      valid_d_r <= equipment_clock_valid;
      state_d_r <= operating_state;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[2:0] = valid_d_r ^ equipment_clock_valid;
    irq_set[serial_reg_pkg::IRQ_OPSTATE] =
      state_d_r != operating_state;
    irq_set[serial_reg_pkg::IRQ_LOSS] = selected_input_lost;
    irq_clr = '0;
    if (wr_evt && addr == serial_reg_pkg::A_IRQ_STS) begin
      irq_clr = wdata[4:0];
    end
  end

  // Set wins over clear; events wait out the post-reset load so
  // input levels differing from the reset copies raise no false event
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      irq_sts_r <= '0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~irq_clr) |
                   (|load_strap_r ? '0 : irq_set);
    end
  end

  // ----------------------------------------------------------------
  // Mask, pin configuration and test mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      irq_mask_r  <= serial_reg_pkg::RST_MASK;
      irq_cfg_r   <= serial_reg_pkg::RST_ICFG;
      test_mode_r <= 1'b0;
    end else if (wr_evt) begin
      if (addr == serial_reg_pkg::A_IRQ_MASK) begin
        irq_mask_r <= wdata[4:0];
      end
      if (addr == serial_reg_pkg::A_IRQ_CFG) begin
        irq_cfg_r <= wdata[1:0];
      end
      // Only a reset leaves test mode
      if (addr >= serial_reg_pkg::A_LIMIT) begin
        test_mode_r <= 1'b1;
      end
    end
  end

  assign test_mode = test_mode_r;

  // ----------------------------------------------------------------
  // Multi-byte configuration word
  // ----------------------------------------------------------------
  // Any access other than the low byte write breaks the sequence.
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      pend_lo_r  <= serial_reg_pkg::RST_BYTE;
      seq_lo_r   <= 1'b0;
      cfg_word_r <= serial_reg_pkg::RST_WORD;
    end else if (wr_evt) begin
      seq_lo_r <= addr == serial_reg_pkg::A_CFG_LO;
      if (addr == serial_reg_pkg::A_CFG_LO) begin
        pend_lo_r <= wdata;
      end
      if (addr == serial_reg_pkg::A_CFG_HI && seq_lo_r) begin
        cfg_word_r <= {wdata, pend_lo_r};
      end
    end else if (rd_evt) begin
      seq_lo_r <= 1'b0;
    end
  end

  assign config_word = cfg_word_r;

  // ----------------------------------------------------------------
  // Status shadows and read freeze
  // ----------------------------------------------------------------
  // Shadows follow live status; a read samples only the shadow so a
  // value moving mid-read cannot tear.
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      live_shadow_r <= serial_reg_pkg::RST_BYTE;
      word_shadow_r <= serial_reg_pkg::RST_WORD;
    end else begin
      live_shadow_r <= {3'h0, operating_state,
                        equipment_clock_valid};
      word_shadow_r <= status_word;
    end
  end

  // Reading the low byte freezes the high byte until the next access
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      frozen_hi_r <= serial_reg_pkg::RST_BYTE;
      frozen_r    <= 1'b0;
    end else if (rd_evt) begin
      frozen_r    <= addr == serial_reg_pkg::A_STS_LO;
      frozen_hi_r <= word_shadow_r[15:8];
    end else if (wr_evt) begin
      frozen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = serial_reg_pkg::RST_BYTE;
    case (addr)
      serial_reg_pkg::A_ID_LO:    rd_mux = CHIP_ID[7:0];
      serial_reg_pkg::A_ID_HI:    rd_mux = CHIP_ID[15:8];
      serial_reg_pkg::A_REV:      rd_mux = CHIP_REV;
      serial_reg_pkg::A_LIVE:     rd_mux = live_shadow_r;
      serial_reg_pkg::A_IRQ_STS:  rd_mux = {3'h0, irq_sts_r};
      serial_reg_pkg::A_IRQ_MASK: rd_mux = {3'h0, irq_mask_r};
      serial_reg_pkg::A_IRQ_CFG:  rd_mux = {6'h00, irq_cfg_r};
      serial_reg_pkg::A_CFG_LO:   rd_mux = cfg_word_r[7:0];
      serial_reg_pkg::A_CFG_HI:   rd_mux = cfg_word_r[15:8];
      serial_reg_pkg::A_STS_LO:   rd_mux = word_shadow_r[7:0];
      serial_reg_pkg::A_STS_HI: begin
        rd_mux = frozen_r ? frozen_hi_r : word_shadow_r[15:8];
      end
      default: begin
        if (addr < serial_reg_pkg::A_LIMIT) begin
          rd_mux = cfg_r[addr];
        end
      end
    endcase
  end

  // Answer toggle follows the request once data is in place
  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      xf.rd_data <= serial_reg_pkg::RST_BYTE;
      xf.rd_ack  <= 1'b0;
    end else if (rd_evt) begin
      xf.rd_data <= rd_mux;
      xf.rd_ack  <= rd_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request pin
  // ----------------------------------------------------------------
  assign irq_act = |(irq_sts_r & irq_mask_r);

  always_ff @(posedge clock or posedge dev_rst_r) begin
    if (dev_rst_r) begin
      irq_out_r <= 1'b0;
      irq_oe_r  <= 1'b0;
    end else begin
      irq_out_r <= irq_cfg_r[serial_reg_pkg::CFG_POL] ~^ irq_act;
      irq_oe_r  <= irq_act |
                   irq_cfg_r[serial_reg_pkg::CFG_DRIVE];
    end
  end

  assign interrupt_request    = irq_out_r;
  assign interrupt_request_oe = irq_oe_r;
endmodule // serial_register_port

/* tb/serial_port_properties.sv */
/*
  Checker on the pins of the serial register port.
  Assumes a bind from the bench top; clock and rst as on the top.
*/
`timescale 1ns/1ps
module serial_port_properties #(
  parameter int POR_HOLD = 20
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        power_on_reset_n,
  input wire logic        chip_select_n,
  input wire logic        serial_data_out_oe,
  input wire logic        interrupt_request,
  input wire logic        interrupt_request_oe,
  input wire logic [15:0] config_word,
  input wire logic        test_mode,
  input wire logic        in_reset
);
  // Hold check needs POR_HOLD of at least 6
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_por_async; !power_on_reset_n |-> in_reset; endproperty
  a_por_async: assert property (p_por_async) else $error("pin reset");
  property p_por_hold; $rose(power_on_reset_n) |-> in_reset [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("hold short");
  property p_rst_async;
    disable iff (!power_on_reset_n) rst |-> in_reset;
  endproperty
  a_rst_async: assert property (p_rst_async) else $error("rst");
  property p_rst_vals; in_reset |-> config_word == 16'h0000 && !test_mode;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("defaults");
  property p_irq_idle; in_reset |-> !interrupt_request_oe; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq in reset");
  property p_irq_dflt; $fell(in_reset) |-> !interrupt_request_oe [*8];
  endproperty
  a_irq_dflt: assert property (p_irq_dflt) else $error("irq dflt");
  property p_test_hold; test_mode |=> test_mode || in_reset; endproperty
  a_test_hold: assert property (p_test_hold) else $error("test mode");
  property p_sdo_idle; chip_select_n [*3] |-> !serial_data_out_oe;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven");
endmodule // serial_port_properties

/* tb/host_master.sv */
/*
  Host model: serial master on its own 48 ns clock.
  Assumes the bench sets output_edge_select before a frame.
*/
`timescale 1ns/1ps
module host_master (
  input  wire logic output_edge_select,
  input  wire logic serial_data_out,
  output logic      serial_clock,
  output logic      chip_select_n,
  output logic      serial_data_in,
  output logic [7:0] rd_byte,
  output int        rd_cnt
);
  initial begin
    {serial_clock, serial_data_in, rd_byte, rd_cnt} = '0;
    chip_select_n = 1'b1;
  end
  // One frame; clock stands still outside frames
  task automatic xfer(input logic [6:0] a, input logic r,
                      input logic [7:0] d);
    logic [23:0] b;
    b = {8'h00, d, r, a};
    #7 chip_select_n = 1'b0;
    for (int i = 0; i < (r ? 24 : 16); i++) begin
      serial_data_in = b[i];
      #24;
      if (output_edge_select && i > 15) rd_byte[i-16] = serial_data_out;
      serial_clock = 1'b1;
      #24 serial_clock = 1'b0;
      // Sample on falling edge, data launched on rising
      if (!output_edge_select && i > 14 && i < 23)
        rd_byte[i-15] = serial_data_out;
    end
    #24 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in; // Released line keeps moving
    if (r) rd_cnt++;
    #300; // Gap above four core clocks
  endtask
endmodule // host_master

/* tb/test_serial_register_port.sv */
/*
  Self-checking bench of the serial register port.
  Assumes the host model and checker compile first.
*/
`timescale 1ns/1ps
module test_serial_register_port;
  localparam logic [15:0] ID = 16'hA5C3; // Arbitrary value
  logic        clock, rst, power_on_reset_n, output_edge_select;
  logic        serial_clock, chip_select_n, serial_data_in;
  logic        serial_data_out, serial_data_out_oe, selected_input_lost;
  logic        interrupt_request, interrupt_request_oe, test_mode, in_reset;
  logic [2:0]  equipment_clock_valid;
  logic [1:0]  operating_state;
  logic [15:0] status_word, config_word;
  logic [7:0]  config_strap, rd_byte, hi;
  logic [31:0] lfsr;
  int          rd_cnt, err_count, total_checks, cycles;
  logic [7:0]  exp_q[$];
  serial_register_port #(.POR_HOLD(20), .CHIP_ID(ID)) uut (.*);
  host_master host (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(a, 1'b0, d);
    @(negedge clock);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(a, 1'b1, 8'h00);
    @(negedge clock);
  endtask
  // Settle time for crossing and the registered pin
  task automatic settle;
    repeat (5) @(negedge clock);
  endtask
  task automatic ready;
    for (int i = 0; i < 99 && in_reset !== 1'b0; i++) @(negedge clock);
    repeat (2) @(negedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (++cycles == 40000) begin
    err_count++;
    finish_test();
  end
  // Watcher takes the oldest note for each read
  always @(rd_cnt) check("read", rd_byte, exp_q.pop_front());
  initial begin
    {rst, power_on_reset_n, lfsr} = {2'h3, 32'h76D9};
    {output_edge_select, equipment_clock_valid, operating_state} = '0;
    {selected_input_lost, status_word} = '0;
    config_strap = lfsr[7:0];
    repeat (5) @(negedge clock);
    rst = 1'b0;
    ready();
    check("cfg", config_word, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      output_edge_select = s[0];
      lfsr = nxt(lfsr);
      rd(7'h07, config_strap);
      rd(7'h00, ID[7:0]);
      wr(7'h20, lfsr[7:0]);
      rd(7'h20, lfsr[7:0]);
    end
    wr(7'h0C, 8'h5A);
    wr(7'h0D, 8'hC3);
    check("cfg", config_word, 16'hC35A);
    wr(7'h0C, 8'h11);
    rd(7'h20, lfsr[7:0]);
    wr(7'h0D, 8'h22);
    check("cfg", config_word, 16'hC35A);
    status_word = lfsr[23:8];
    hi = lfsr[23:16];
    rd(7'h0E, lfsr[15:8]);
    status_word = ~status_word;
    rd(7'h0F, hi);
    wr(7'h5A, 8'h03);
    @(negedge clock) selected_input_lost = 1'b1;
    @(negedge clock) selected_input_lost = 1'b0;
    settle();
    check("irq", {interrupt_request_oe, interrupt_request}, 2'h2);
    wr(7'h06, 8'h10);
    check("irq", interrupt_request, 1'b1);
    {operating_state, equipment_clock_valid} = 5'h11;
    settle();
    rd(7'h05, 8'h19);
    rd(7'h03, 8'h11);
    wr(7'h05, 8'h10);
    settle();
    check("irq", interrupt_request, 1'b0);
    rd(7'h05, 8'h09);
    wr(7'h5A, 8'h00);
    settle();
    check("irq_oe", interrupt_request_oe, 1'b0);
    wr(7'h06, 8'h08);
    settle();
    check("irq", {interrupt_request_oe, interrupt_request}, 2'h2);
    wr(7'h5B, 8'h00);
    settle();
    check("tmode", test_mode, 1'b1);
    power_on_reset_n = 1'b0;
    @(negedge clock) power_on_reset_n = 1'b1;
    check("tmode", {in_reset, test_mode}, 2'h2);
    ready();
    rd(7'h06, 8'h00);
    rd(7'h05, 8'h00);
    check("left", exp_q.size(), 16'h0000);
    finish_test();
  end
endmodule // test_serial_register_port
bind serial_register_port serial_port_properties #(.POR_HOLD(POR_HOLD)) chk (
  .clock, .rst, .power_on_reset_n, .chip_select_n, .serial_data_out_oe,
  .interrupt_request, .interrupt_request_oe, .config_word, .test_mode,
  .in_reset);
